// File: fpex_pkg.sv
package fpex_pkg;

	// operation classes
	localparam logic [2:0] OPC_REG_REG = 3'h0;
	localparam logic [2:0] OPC_MEM_REG = 3'h2;
	localparam logic [2:0] OPC_REG_MEM = 3'h3;

	// saved frame formats
	localparam logic [3:0] FMT_PRE = 4'h0;
	localparam logic [3:0] FMT_POST = 4'h3;

	// vector numbers
	localparam logic [7:0] VEC_UNORDERED = 8'h30;
	localparam logic [7:0] VEC_INEXACT = 8'h31;
	localparam logic [7:0] VEC_DIV_ZERO = 8'h32;
	localparam logic [7:0] VEC_UNDERFLOW = 8'h33;
	localparam logic [7:0] VEC_OPERAND_ERR = 8'h34;
	localparam logic [7:0] VEC_OVERFLOW = 8'h35;
	localparam logic [7:0] VEC_SIGNALING_NAN = 8'h36;
	localparam logic [7:0] VEC_UNSUPPORTED = 8'h37;

	// exception bit positions, highest priority in bit 7
	localparam int unsigned EB_UNORDERED = 7;
	localparam int unsigned EB_SIGNALING_NAN = 6;
	localparam int unsigned EB_OPERAND_ERR = 5;
	localparam int unsigned EB_OVERFLOW = 4;
	localparam int unsigned EB_UNDERFLOW = 3;
	localparam int unsigned EB_DIV_ZERO = 2;
	localparam int unsigned EB_INEXACT_RES = 1;
	localparam int unsigned EB_INEXACT_DEC = 0;
	localparam int unsigned EXC_LSB = 8;

	// bits hardware may set, bits that have a nonmaskable form
	localparam logic [7:0] HW_SET_MASK = 8'hFE;
	localparam logic [7:0] NONMASK_MASK = 8'h78;
	localparam logic [7:0] UNDERFLOW_BIT = 8'h08;

	// register byte addresses
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STAT = 5'h04;
	localparam logic [4:0] REG_ETEMP0 = 5'h08;
	localparam logic [4:0] REG_ETEMP1 = 5'h0C;
	localparam logic [4:0] REG_ETEMP2 = 5'h10;
	localparam logic [4:0] REG_FPTEMP0 = 5'h14;
	localparam logic [4:0] REG_FPTEMP1 = 5'h18;
	localparam logic [4:0] REG_FPTEMP2 = 5'h1C;

	// reset values
	localparam logic [7:0] ENABLE_RST = 8'h00;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [95:0] TEMP_RST = 96'h0;

	// one instruction's outcome from the execution pipeline
	typedef struct packed {
		logic valid;
		logic [2:0] op_class;
		logic src_denorm;
		logic src_unnorm;
		logic dst_denorm;
		logic dst_unnorm;
		logic src_packed;
		logic dst_packed;
		logic result_denorm;
		logic [7:0] exc_set;
		logic [7:0] nonmask_set;
	} fpex_instr_t;

	// exception request to the integer sequencer
	typedef struct packed {
		logic take;
		logic post;
		logic [3:0] format;
		logic [7:0] vector;
	} fpex_take_t;

	// vector of the exception at a priority index
	function automatic logic [7:0] fpex_vector(input logic [2:0] idx);
		logic [7:0] v;
		v = VEC_INEXACT;
		unique case (idx)
			3'h7: v = VEC_UNORDERED;
			3'h6: v = VEC_SIGNALING_NAN;
			3'h5: v = VEC_OPERAND_ERR;
			3'h4: v = VEC_OVERFLOW;
			3'h3: v = VEC_UNDERFLOW;
			3'h2: v = VEC_DIV_ZERO;
			3'h1: v = VEC_INEXACT;
			3'h0: v = VEC_INEXACT;
		endcase
		return v;
	endfunction

endpackage

// File: fpex_prio_enc.sv
module fpex_prio_enc #(
	parameter int N = 8,
	parameter int IW = 3
) (
	input wire logic [N-1:0] req,
	output logic any,
	output logic [IW-1:0] idx
);

	// highest set bit wins, later iterations override
	always_comb begin
		idx = '0;
		for (int i = 0; i < N; i++) begin
			if (req[i]) begin
				idx = IW'(i);
			end
		end
	end

	assign any = |req;

endmodule

// File: fpex_detect.sv
// Our own choices: the placing of the registers and strobed register access.
module fpex_detect
	import fpex_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire fpex_instr_t instr,
	input wire logic [95:0] src_operand,
	input wire logic [95:0] dst_operand,
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output fpex_take_t take
);

	logic [7:0] enable_reg;
	logic [7:0] status_reg;
	logic pend_reg;
	logic [7:0] pend_vec_reg;
	logic [95:0] exception_operand_temp_reg;
	logic [95:0] destination_operand_temp_reg;
	logic [31:0] rdata_reg;
	fpex_take_t take_reg;
	logic [7:0] enable_next;
	logic [7:0] status_next;
	fpex_take_t take_next;

	// instruction accepted for execution when nothing is pending
	wire go = instr.valid & ~pend_reg;
	wire ctrl_wr = reg_wr & (reg_addr == REG_CTRL);
	wire stat_wr = reg_wr & (reg_addr == REG_STAT);

	// unsupported operand detection by operation class
	wire odd_operand = instr.src_denorm | instr.src_unnorm
		| instr.dst_denorm | instr.dst_unnorm
		| instr.src_packed | instr.dst_packed;
	wire class_pre = (instr.op_class == OPC_REG_REG)
		| (instr.op_class == OPC_MEM_REG);
	wire class_post = (instr.op_class == OPC_REG_MEM);
	wire unsupp = go & odd_operand & (class_pre | class_post);
	wire exec = go & ~unsupp;

	// status bits set by execution, denormal result as underflow
	wire [7:0] under_bit = instr.result_denorm ? UNDERFLOW_BIT : 8'h00;
	wire [7:0] hw_set = exec ? ((instr.exc_set | under_bit)
		& HW_SET_MASK) : 8'h00;
	wire [7:0] nm = exec ? ((instr.nonmask_set | under_bit)
		& NONMASK_MASK) : 8'h00;
	wire [7:0] trig = hw_set & enable_reg;
	wire [7:0] cand = trig | nm;
	wire hi_any;
	wire [2:0] hi_idx;
	wire [7:0] hi_vec = fpex_vector(hi_idx);
	wire hi_unordered = hi_any & (hi_idx == 3'(EB_UNORDERED));
	wire arm_pend = exec & hi_any & ~hi_unordered & ~(|nm);

	// highest candidate wins
	fpex_prio_enc #(
		.N(8),
		.IW(3)
	) u_prio (
		.req(cand),
		.any(hi_any),
		.idx(hi_idx)
	);

	// software writes; set from execution wins over the write
	assign enable_next = ctrl_wr ? reg_wdata[EXC_LSB +: 8] : enable_reg;
	assign status_next = (stat_wr ? reg_wdata[EXC_LSB +: 8] : status_reg)
		| hw_set;

	// exception decision for this cycle
	always_comb begin
		take_next = '0;
		if (instr.valid && pend_reg) begin
			take_next.take = 1'b1;
			take_next.format = FMT_PRE;
			take_next.vector = pend_vec_reg;
		end else if (unsupp) begin
			take_next.take = 1'b1;
			take_next.post = class_post;
			take_next.format = class_post ? FMT_POST : FMT_PRE;
			take_next.vector = VEC_UNSUPPORTED;
		end else if (exec && hi_unordered) begin
			take_next.take = 1'b1;
			take_next.format = FMT_PRE;
			take_next.vector = VEC_UNORDERED;
		end else if (exec && (|nm)) begin
			take_next.take = 1'b1;
			take_next.post = 1'b1;
			take_next.format = FMT_POST;
			take_next.vector = hi_vec;
		end
	end

	// control and status registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			enable_reg <= ENABLE_RST;
			status_reg <= STATUS_RST;
		end else begin
			enable_reg <= enable_next;
			status_reg <= status_next;
		end
	end

	// pending maskable exception until the next instruction
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pend_reg <= 1'b0;
			pend_vec_reg <= 8'h00;
		end else if (instr.valid && pend_reg) begin
			pend_reg <= 1'b0;
		end else if (arm_pend) begin
			pend_reg <= 1'b1;
			pend_vec_reg <= hi_vec;
		end
	end

	// operand temporaries captured on unsupported operands
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			exception_operand_temp_reg <= TEMP_RST;
			destination_operand_temp_reg <= TEMP_RST;
		end else if (unsupp && instr.src_packed) begin
			destination_operand_temp_reg <= {64'h0, src_operand[95:64]};
			exception_operand_temp_reg <= {32'h0, src_operand[63:0]};
		end else if (unsupp) begin
			exception_operand_temp_reg <= src_operand;
			destination_operand_temp_reg <= dst_operand;
		end
	end

	// read data selection
	wire [31:0] rd_mux =
		(reg_addr == REG_CTRL) ? {16'h0, enable_reg, 8'h00} :
		(reg_addr == REG_STAT) ? {16'h0, status_reg, 7'h00, pend_reg} :
		(reg_addr == REG_ETEMP0) ? exception_operand_temp_reg[31:0] :
		(reg_addr == REG_ETEMP1) ? exception_operand_temp_reg[63:32] :
		(reg_addr == REG_ETEMP2) ? exception_operand_temp_reg[95:64] :
		(reg_addr == REG_FPTEMP0) ? destination_operand_temp_reg[31:0] :
		(reg_addr == REG_FPTEMP1) ? destination_operand_temp_reg[63:32] :
		(reg_addr == REG_FPTEMP2) ? destination_operand_temp_reg[95:64] : 32'h0;

	// registered outputs
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata_reg <= 32'h0;
			take_reg <= '0;
		end else begin
			rdata_reg <= reg_rd ? rd_mux : 32'h0;
			take_reg <= take_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign take = take_reg;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence s_unsupp_pre;
		go && odd_operand && class_pre;
	endsequence

	sequence s_frame_pre(logic [7:0] v);
		take.take && !take.post && take.format == FMT_PRE && take.vector == v;
	endsequence

	sequence s_frame_post;
		take.take && take.post && take.format == FMT_POST;
	endsequence

	property p_unsupp_pre;
		s_unsupp_pre |=> s_frame_pre(VEC_UNSUPPORTED);
	endproperty
	a_unsupp_pre: assert property (p_unsupp_pre)
		else $error("unsupported operand pre frame wrong");

	property p_unsupp_post;
		go && odd_operand && class_post
			|=> s_frame_post ##0 take.vector == VEC_UNSUPPORTED;
	endproperty
	a_unsupp_post: assert property (p_unsupp_post)
		else $error("unsupported operand post frame wrong");

	property p_packed_any;
		go && instr.dst_packed && class_pre |=> take.vector == 8'h37;
	endproperty
	a_packed_any: assert property (p_packed_any)
		else $error("packed destination not flagged");

	property p_packed_split;
		unsupp && instr.src_packed
			|=> destination_operand_temp_reg[31:0] == $past(src_operand[95:64])
			&& exception_operand_temp_reg[63:0] == $past(src_operand[63:0]);
	endproperty
	a_packed_split: assert property (p_packed_split)
		else $error("packed operand split wrong");

	property p_temp_copy;
		unsupp && !instr.src_packed
			|=> exception_operand_temp_reg == $past(src_operand)
			&& destination_operand_temp_reg == $past(dst_operand);
	endproperty
	a_temp_copy: assert property (p_temp_copy)
		else $error("operand temporaries not copied");

	property p_inex_dec;
		$rose(status_reg[EB_INEXACT_DEC]) |-> $past(stat_wr);
	endproperty
	a_inex_dec: assert property (p_inex_dec)
		else $error("inexact decimal set by hardware");

	property p_sw_quiet;
		(stat_wr || ctrl_wr) && !instr.valid && !pend_reg
			|=> !take.take && !pend_reg;
	endproperty
	a_sw_quiet: assert property (p_sw_quiet)
		else $error("software write caused an exception");

	property p_unordered;
		exec && instr.exc_set[EB_UNORDERED] && enable_reg[EB_UNORDERED]
			|=> s_frame_pre(VEC_UNORDERED);
	endproperty
	a_unordered: assert property (p_unordered)
		else $error("unordered exception not taken");

	property p_denorm_result;
		exec && instr.result_denorm
			|=> s_frame_post ##0 status_reg[EB_UNDERFLOW];
	endproperty
	a_denorm_result: assert property (p_denorm_result)
		else $error("denormal result not underflow");

	property p_nan_first;
		exec && instr.nonmask_set[EB_OVERFLOW]
			&& trig[EB_SIGNALING_NAN] && !trig[EB_UNORDERED]
			|=> take.vector == VEC_SIGNALING_NAN;
	endproperty
	a_nan_first: assert property (p_nan_first)
		else $error("lower priority exception reported");

	property p_masked_off;
		exec && trig == 8'h00 && nm == 8'h00 |=> !take.take && !pend_reg;
	endproperty
	a_masked_off: assert property (p_masked_off)
		else $error("disabled exception was taken");

	property p_pending;
		pend_reg && instr.valid
			|=> s_frame_pre($past(pend_vec_reg)) ##0 !pend_reg;
	endproperty
	a_pending: assert property (p_pending)
		else $error("pending exception not reported");

	property p_arm;
		arm_pend |=> pend_reg && !take.take;
	endproperty
	a_arm: assert property (p_arm)
		else $error("maskable exception not held pending");

	property p_status_keep;
		exec |=> (status_reg & $past(hw_set)) == $past(hw_set);
	endproperty
	a_status_keep: assert property (p_status_keep)
		else $error("status bits set by execution lost");

	property p_take_cause;
		take.take |-> $past(instr.valid);
	endproperty
	a_take_cause: assert property (p_take_cause)
		else $error("exception reported without an instruction");

	property p_underflow_only;
		exec && nm == UNDERFLOW_BIT && trig[7:4] == 4'h0
			|=> s_frame_post ##0 take.vector == VEC_UNDERFLOW;
	endproperty
	a_underflow_only: assert property (p_underflow_only)
		else $error("nonmaskable underflow vector wrong");

endmodule

// File: fpex_seq_model.sv
// integer unit sequencer stand-in: counts each exception request and keeps the last one
module fpex_seq_model
	import fpex_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire fpex_take_t take,
	output logic [7:0] take_count,
	output fpex_take_t last_take
);
	timeunit 1ns;
	timeprecision 1ps;

	// the sequencer accepts a request in the cycle it stands, never stalls
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			take_count <= 8'h00;
			last_take <= '0;
		end else if (take.take === 1'b1) begin
			take_count <= take_count + 8'h01;
			last_take <= take;
		end
	end
endmodule

// File: testbench.sv
module testbench
	import fpex_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock = 1'b0;
	logic rstn = 1'b0;
	fpex_instr_t instr = '0;
	logic [95:0] src_operand = '0;
	logic [95:0] dst_operand = '0;
	logic [4:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	fpex_take_t take;
	logic [7:0] take_count;
	fpex_take_t last_take;
	int fails = 0;
	int total_checks = 0;
	localparam fpex_take_t NONE = '0;
	localparam logic [95:0] SRC = 96'hA5A50123_456789AB_CDEF1357;
	localparam logic [95:0] DST = 96'h0F0F1111_22223333_44445555;

	always #12.5 clock = ~clock;

	fpex_detect u_dut (.clock(clock), .rstn(rstn), .instr(instr),
		.src_operand(src_operand), .dst_operand(dst_operand),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .take(take));

	fpex_seq_model u_seq (.clock(clock), .rstn(rstn), .take(take),
		.take_count(take_count), .last_take(last_take));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_take(input fpex_take_t got, input fpex_take_t exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: take %h expected %h", $time, got, exp);
		end
	endtask

	function automatic fpex_instr_t mi(input logic [2:0] c,
		input logic [5:0] f, input logic rd, input logic [7:0] x,
		input logic [7:0] n);
		return {1'b1, c, f, rd, x, n};
	endfunction

	function automatic fpex_take_t mt(input logic p, input logic [7:0] v);
		return {1'b1, p, (p ? FMT_POST : FMT_PRE), v};
	endfunction

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk_word(reg_rdata, e);
	endtask

	// one instruction, take judged in the single cycle after it
	task automatic run(input fpex_instr_t i, input fpex_take_t e);
		@(posedge clock);
		instr <= i;
		src_operand <= SRC;
		dst_operand <= DST;
		@(posedge clock);
		instr <= '0;
		#1 chk_take(take, e);
	endtask

	task automatic temps(input logic [191:0] e);
		for (int i = 0; i < 6; i++) begin
			rd(REG_ETEMP0 + 5'(4 * i), e[32*i +: 32]);
		end
	endtask

	task automatic t_reset();
		rd(REG_CTRL, 32'h0);
		rd(REG_STAT, 32'h0);
		wr(REG_ETEMP0, 32'hFFFFFFFF);
		rd(REG_ETEMP0, 32'h0);
		rd(5'h1E, 32'h0);
	endtask

	task automatic t_unsup();
		logic [2:0] cls [3] = '{OPC_REG_MEM, OPC_REG_REG, OPC_MEM_REG};
		logic [2:0] c;
		for (int k = 0; k < 6; k++) begin
			c = cls[k % 3];
			run(mi(c, 6'h20 >> k, 1'b0, 8'h04, 8'h0),
				mt(c == OPC_REG_MEM, VEC_UNSUPPORTED));
		end
		rd(REG_STAT, 32'h0);
		temps({DST, SRC});
		run(mi(OPC_MEM_REG, 6'h02, 1'b0, 8'h0, 8'h0), mt(1'b0, VEC_UNSUPPORTED));
		temps({64'h0, SRC[95:64], 32'h0, SRC[63:0]});
	endtask

	task automatic t_mask();
		wr(REG_CTRL, 32'h00000400);
		run(mi(OPC_REG_REG, 6'h0, 1'b0, 8'h04, 8'h0), NONE);
		rd(REG_STAT, 32'h00000401);
		run(mi(OPC_REG_REG, 6'h0, 1'b0, 8'h02, 8'h0), mt(1'b0, VEC_DIV_ZERO));
		rd(REG_STAT, 32'h00000400);
		wr(REG_CTRL, 32'h0);
		wr(REG_STAT, 32'h0);
		run(mi(OPC_REG_REG, 6'h0, 1'b0, 8'h04, 8'h0), NONE);
		rd(REG_STAT, 32'h00000400);
	endtask

	task automatic t_prio();
		wr(REG_STAT, 32'h0);
		wr(REG_CTRL, 32'h0000FF00);
		run(mi(OPC_REG_REG, 6'h0, 1'b0, 8'h26, 8'h0), NONE);
		rd(REG_STAT, 32'h00002601);
		run(mi(OPC_REG_REG, 6'h0, 1'b0, 8'h0, 8'h0), mt(1'b0, VEC_OPERAND_ERR));
		run(mi(OPC_REG_REG, 6'h0, 1'b0, 8'hC0, 8'h0), mt(1'b0, VEC_UNORDERED));
		run(mi(OPC_REG_MEM, 6'h0, 1'b0, 8'h40, 8'h10),
			mt(1'b1, VEC_SIGNALING_NAN));
	endtask

	task automatic t_soft();
		wr(REG_CTRL, 32'h0);
		wr(REG_STAT, 32'h0000FF00);
		wr(REG_CTRL, 32'h0000FF00);
		run(mi(OPC_REG_REG, 6'h0, 1'b0, 8'h0, 8'h0), NONE);
		rd(REG_STAT, 32'h0000FF00);
		wr(REG_STAT, 32'h0);
		run(mi(OPC_REG_REG, 6'h0, 1'b0, 8'h01, 8'h0), NONE);
		rd(REG_STAT, 32'h0);
	endtask

	task automatic t_nonmask();
		logic [7:0] v [4] = '{VEC_UNDERFLOW, VEC_OVERFLOW, VEC_OPERAND_ERR,
			VEC_SIGNALING_NAN};
		wr(REG_CTRL, 32'h0);
		for (int b = 3; b < 7; b++) begin
			run(mi(OPC_REG_MEM, 6'h0, 1'b0, 8'h0, 8'h01 << b),
				mt(1'b1, v[b - 3]));
		end
		run(mi(OPC_REG_REG, 6'h0, 1'b1, 8'h0, 8'h0), mt(1'b1, VEC_UNDERFLOW));
	endtask

	// watchdog sized well beyond the roughly 114 cycles of the run
	initial begin
		#100000;
		fails++;
		report_and_stop();
	end

	initial begin
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		t_reset();
		t_unsup();
		t_mask();
		t_prio();
		t_soft();
		t_nonmask();
		@(posedge clock);
		#1 chk_word({24'h0, take_count}, 32'h10);
		chk_take(last_take, mt(1'b1, VEC_UNDERFLOW));
		report_and_stop();
	end
endmodule
